// >>> hdl/ipl_pkg.sv
// ipl_pkg: constants for the interrupt priority level configuration block
// assumes an Avalon-MM slave port with 32-bit data and byte addresses

package ipl_pkg;

  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned FIELD_W   = 2;
  localparam int unsigned NUM_SRC   = 12;
  localparam int unsigned NUM_LVL   = 3;
  localparam int unsigned NUM_REG   = 3;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CFG_2 = 8'h02;
  localparam logic [ADDR_W-1:0] IDX_CFG_3 = 8'h03;
  localparam logic [ADDR_W-1:0] IDX_CFG_4 = 8'h04;

  // field reset value: disabled
  localparam logic [FIELD_W-1:0] LVL_DISABLED = 2'h0;
  localparam logic [FIELD_W-1:0] LVL_CODE_0   = 2'h1;
  localparam logic [FIELD_W-1:0] LVL_CODE_1   = 2'h2;
  localparam logic [FIELD_W-1:0] LVL_CODE_2   = 2'h3;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // --------------------------------------------------------------------
  // source numbering and field placement
  // --------------------------------------------------------------------
  // 0 flash_error   1 pll_unlock   2 low_voltage   3 ext_request_a
  // 4 can_msg_buf   5 can_wakeup   6 can_error     7 can_bus_off
  // 8 serial0_rx    9 serial1_tx  10 serial1_rx   11..13 ports a..c
  localparam int unsigned NUM_FIELDS = 14;

  // which register (0 = cfg_2, 1 = cfg_3, 2 = cfg_4) holds each field
  localparam int unsigned SRC_REG [NUM_FIELDS] = '{
    0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2};

  // low bit of each field
  localparam int unsigned SRC_LSB [NUM_FIELDS] = '{
    10, 8, 6, 0,
    8, 6, 4, 2,
    14, 12, 10, 4, 2, 0};

  // writable bit masks per register; other bits are reserved
  localparam logic [REG_W-1:0] MASK_CFG_2 = 16'h0FC3;
  localparam logic [REG_W-1:0] MASK_CFG_3 = 16'h03FC;
  localparam logic [REG_W-1:0] MASK_CFG_4 = 16'hFC3F;

endpackage : ipl_pkg

// >>> hdl/ipl_level_regs.sv
// ipl_level_regs: priority level configuration for fourteen interrupt
// sources, with an Avalon-MM slave and request gating per level.
// assumes source requests are levels from logic on clock_i.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps

module ipl_level_regs (
  input  wire logic                           clock_i,
  input  wire logic                           sys_rst_i,
  // avalon-mm slave
  input  wire logic [ipl_pkg::ADDR_W-1:0]     avs_address_i,
  input  wire logic                           avs_read_i,
  input  wire logic                           avs_write_i,
  input  wire logic [ipl_pkg::DATA_W-1:0]     avs_writedata_i,
  input  wire logic [3:0]                     avs_byteenable_i,
  output logic      [ipl_pkg::DATA_W-1:0]     avs_readdata_o,
  output logic      [1:0]                     avs_response_o,
  output logic                                avs_waitrequest_o,
  // interrupt sources and forwarded requests
  input  wire logic [ipl_pkg::NUM_FIELDS-1:0] src_req_i,
  output logic      [ipl_pkg::NUM_FIELDS-1:0] src_fwd_o,
  output logic      [ipl_pkg::NUM_LVL-1:0]    level_req_o
);

  // --------------------------------------------------------------------
  // decoding helpers
  // --------------------------------------------------------------------

  // field code to one-hot level, bit n = level n; 00 gives none
  function automatic logic [ipl_pkg::NUM_LVL-1:0] lvl_onehot(
    input logic [ipl_pkg::FIELD_W-1:0] code
  );
    case (code)
      ipl_pkg::LVL_CODE_0: lvl_onehot = 3'h1;
      ipl_pkg::LVL_CODE_1: lvl_onehot = 3'h2;
      ipl_pkg::LVL_CODE_2: lvl_onehot = 3'h4;
      default:             lvl_onehot = 3'h0;
    endcase
  endfunction : lvl_onehot

  // byte address to register slot, NUM_REG when unmapped
  function automatic logic [1:0] reg_slot(
    input logic [ipl_pkg::ADDR_W-1:0] addr
  );
    if (addr[1:0] != 2'h0) begin
      reg_slot = 2'h3;
    end else if (addr[ipl_pkg::ADDR_W-1:2] == ipl_pkg::IDX_CFG_2[5:0]) begin
      reg_slot = 2'h0;
    end else if (addr[ipl_pkg::ADDR_W-1:2] == ipl_pkg::IDX_CFG_3[5:0]) begin
      reg_slot = 2'h1;
    end else if (addr[ipl_pkg::ADDR_W-1:2] == ipl_pkg::IDX_CFG_4[5:0]) begin
      reg_slot = 2'h2;
    end else begin
      reg_slot = 2'h3;
    end
  endfunction : reg_slot

  // register slot to its writable bits; reserved bits are zero
  function automatic logic [15:0] reg_mask(
    input logic [1:0] sl
  );
    case (sl)
      2'h0:    reg_mask = ipl_pkg::MASK_CFG_2;
      2'h1:    reg_mask = ipl_pkg::MASK_CFG_3;
      2'h2:    reg_mask = ipl_pkg::MASK_CFG_4;
      default: reg_mask = 16'h0000;
    endcase
  endfunction : reg_mask

  // --------------------------------------------------------------------
  // bus handshake
  // --------------------------------------------------------------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;
  logic        req;
  logic        accept;
  logic [1:0]  slot;
  logic [15:0] wmask;

  assign req    = avs_read_i | avs_write_i;
  assign accept = req & ~wait_q;  // edge where master sees waitrequest low
  assign slot   = reg_slot(avs_address_i);
  assign wmask  = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // bus handshake states, one-hot; one wait state, then one answer
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,   // waitrequest high, watching for a request
    ST_ANSWER = 2'b10    // waitrequest low, master takes the answer
  } ipl_bus_state_t;

  ipl_bus_state_t state_q;
  ipl_bus_state_t state_d;

  // next state: every request gets exactly one wait state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req) begin
          state_d = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        state_d = ST_IDLE;   // next request waits again
      end
      default: begin
        state_d = ST_IDLE;   // recover from an illegal code
      end
    endcase
  end

  // handshake state register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // waitrequest is the idle bit of the state register
  assign wait_q = state_q[0];

  // --------------------------------------------------------------------
  // level fields
  // --------------------------------------------------------------------
  logic [ipl_pkg::FIELD_W-1:0] lvl_q [ipl_pkg::NUM_FIELDS];
  logic [ipl_pkg::FIELD_W-1:0] lvl_d [ipl_pkg::NUM_FIELDS];
  logic [15:0]                 reg_img [ipl_pkg::NUM_REG];
  logic [ipl_pkg::NUM_REG-1:0] wr_sel;
  logic [15:0]                 wr_keep [ipl_pkg::NUM_REG];
  logic [15:0]                 wr_data [ipl_pkg::NUM_REG];

  genvar gi;
  genvar gr;

  // per register: write strobe and the bits it may change
  generate
    for (gr = 0; gr < ipl_pkg::NUM_REG; gr++) begin : g_reg
      // strobe only at the edge where the master sees waitrequest low
      assign wr_sel[gr]  = accept && avs_write_i && (slot == 2'(gr));
      // reserved bits never take write data
      assign wr_data[gr] = avs_writedata_i[15:0] & wmask
                         & reg_mask(2'(gr));
      // bits left alone: disabled lanes and reserved bits
      assign wr_keep[gr] = ~(wmask & reg_mask(2'(gr)));
    end
  endgenerate

  generate
    for (gi = 0; gi < ipl_pkg::NUM_FIELDS; gi++) begin : g_field
      localparam int unsigned RI = ipl_pkg::SRC_REG[gi];
      localparam int unsigned LB = ipl_pkg::SRC_LSB[gi];

      // next value: merge write data through its lane mask
      always_comb begin
        lvl_d[gi] = lvl_q[gi];
        if (wr_sel[RI]) begin
          lvl_d[gi] = wr_data[RI][LB +: 2]
                    | (lvl_q[gi] & wr_keep[RI][LB +: 2]);
        end
      end

      // field register
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          lvl_q[gi] <= ipl_pkg::LVL_DISABLED;
        end else begin
          lvl_q[gi] <= lvl_d[gi];
        end
      end
    end
  endgenerate

  // register images; reserved bits stay zero
  always_comb begin
    for (int r = 0; r < ipl_pkg::NUM_REG; r++) begin
      reg_img[r] = 16'h0000;
    end
    for (int f = 0; f < ipl_pkg::NUM_FIELDS; f++) begin
      reg_img[ipl_pkg::SRC_REG[f]][ipl_pkg::SRC_LSB[f] +: 2] = lvl_q[f];
    end
  end

  logic [31:0] rdata_d;
  logic [1:0]  resp_d;

  // answer for the addressed slot; unmapped and misaligned refused
  always_comb begin
    rdata_d = rdata_q;
    resp_d  = resp_q;
    if (req && wait_q) begin
      if (slot == 2'h3) begin
        rdata_d = 32'h0000_0000;
        resp_d  = ipl_pkg::RESP_SLVERR;
      end else begin
        rdata_d = {16'h0000, reg_img[slot]};
        resp_d  = ipl_pkg::RESP_OKAY;
      end
    end
  end

  // read data and response, loaded in the wait state
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
      resp_q  <= ipl_pkg::RESP_OKAY;
    end else begin
      rdata_q <= rdata_d;
      resp_q  <= resp_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;
  assign avs_response_o    = resp_q;

  // --------------------------------------------------------------------
  // request gating per level
  // --------------------------------------------------------------------
  logic [ipl_pkg::NUM_FIELDS-1:0] fwd_q;
  logic [ipl_pkg::NUM_FIELDS-1:0] fwd_d;
  logic [ipl_pkg::NUM_LVL-1:0]    lvl_req_q;
  logic [ipl_pkg::NUM_LVL-1:0]    lvl_any;
  logic [ipl_pkg::NUM_LVL-1:0]    src_oh [ipl_pkg::NUM_FIELDS];
  logic [ipl_pkg::NUM_FIELDS-1:0] lvl_col [ipl_pkg::NUM_LVL];

  genvar gs;
  genvar gl;

  // per source: gate by its field and decode its level
  generate
    for (gs = 0; gs < ipl_pkg::NUM_FIELDS; gs++) begin : g_src
      // a disabled field drops the request
      assign fwd_d[gs]  = src_req_i[gs]
                          && (lvl_q[gs] != ipl_pkg::LVL_DISABLED);
      // one-hot level of a requesting source, zero otherwise
      assign src_oh[gs] = src_req_i[gs] ? lvl_onehot(lvl_q[gs])
                                        : 3'h0;
    end
  endgenerate

  // per level: which sources ask for it, then their or
  generate
    for (gl = 0; gl < ipl_pkg::NUM_LVL; gl++) begin : g_lvl
      always_comb begin
        lvl_col[gl] = '0;
        for (int f = 0; f < ipl_pkg::NUM_FIELDS; f++) begin
          lvl_col[gl][f] = src_oh[f][gl];
        end
      end
      assign lvl_any[gl] = |lvl_col[gl];
    end
  endgenerate

  // registered forwarding outputs
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      fwd_q     <= '0;
      lvl_req_q <= 3'h0;
    end else begin
      fwd_q     <= fwd_d;
      lvl_req_q <= lvl_any;
    end
  end

  assign src_fwd_o   = fwd_q;
  assign level_req_o = lvl_req_q;

endmodule : ipl_level_regs

// >>> dv/ipl_level_regs_asserts.sv
// checker: bus answer and request gating of the level block
// assumes a bind onto ipl_level_regs in the bench top file
`timescale 1ns/100ps
module ipl_level_regs_asserts (
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [1:0]  avs_response_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [13:0] src_req_i,
  input wire logic [13:0] src_fwd_o,
  input wire logic [2:0]  level_req_o
);
  logic        ok_a;
  logic [15:0] msk;
  // decode of the addressed register and its writable bits
  assign ok_a = avs_address_i inside {8'h08, 8'h0C, 8'h10};
  assign msk = (avs_address_i == 8'h08) ? 16'h0FC3 :
               (avs_address_i == 8'h0C) ? 16'h03FC : 16'hFC3F;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low twice");
  a_wait_cause: assert property (!avs_waitrequest_o |->
    $past(avs_read_i | avs_write_i)) else $error("answer without request");
  a_upper_zero: assert property (avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_rsv_zero: assert property (
    !avs_waitrequest_o && $past(avs_read_i) && $past(ok_a) |->
    (avs_readdata_o[15:0] & ~$past(msk)) == 16'h0000)
    else $error("reserved bit read as one");
  a_bad_addr: assert property (
    !avs_waitrequest_o && $past(avs_read_i) && !$past(ok_a) |->
    avs_response_o == 2'h2 && avs_readdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_good_addr: assert property (!avs_waitrequest_o && $past(ok_a) |->
    avs_response_o == 2'h0) else $error("mapped access refused");
  a_fwd_gate: assert property (
    (src_fwd_o & ~$past(src_req_i)) == 14'h0)
    else $error("request forwarded without source");
  a_lvl_fwd: assert property (
    (level_req_o != 3'h0) == (src_fwd_o != 14'h0))
    else $error("level and forward disagree");
  a_rst_quiet: assert property ($past(sys_rst_i) |->
    src_fwd_o == 14'h0 && level_req_o == 3'h0 && avs_waitrequest_o)
    else $error("outputs active after reset");
endmodule : ipl_level_regs_asserts

// >>> dv/ipl_src_model.sv
// source model: peripheral request levels toward the block
// assumes levels change only just after clock_i edges
`timescale 1ns/100ps
module ipl_src_model (
  input  wire logic [13:0] want_i,
  output logic      [13:0] req_o
);
  // plain level sources, no pulse shaping
  assign req_o = want_i;
endmodule : ipl_src_model

// >>> dv/ipl_level_regs_tb_top.sv
// testbench: register access and request gating of ipl_level_regs
// assumes the checker and source model are compiled before it
`timescale 1ns/100ps
module ipl_level_regs_tb_top;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [13:0] want = 14'h0;
  logic [31:0] rdat;
  logic [1:0]  rsp;
  logic        wreq;
  logic [13:0] req;
  logic [13:0] fwd;
  logic [2:0]  lvl;
  int          fail_count = 0;
  int          n_checks = 0;
  localparam int LSB [14] = '{10, 8, 6, 0, 8, 6, 4, 2, 14, 12, 10, 4, 2, 0};
  localparam logic [15:0] MSK [3] = '{16'h0FC3, 16'h03FC, 16'hFC3F};
  ipl_level_regs u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_response_o(rsp), .avs_waitrequest_o(wreq), .src_req_i(req),
    .src_fwd_o(fwd), .level_req_o(lvl));
  ipl_src_model u_src (.want_i(want), .req_o(req));
  // 20 MHz clock
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d = 32'h0, input logic [3:0] b = 4'hF);
    @(posedge clock_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    do @(posedge clock_i); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // watchdog against a hung handshake
  initial begin
    #(50 * 5000);
    fail_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      bus(0, 8'(8 + 4 * r));
      chk("reset value", rdat, 32'h0);
      bus(1, 8'(8 + 4 * r), 32'hFFFFFFFF);
      bus(0, 8'(8 + 4 * r));
      chk("full write", rdat, {16'h0, MSK[r]});
      bus(1, 8'(8 + 4 * r), 32'h0, 4'h1);
      bus(0, 8'(8 + 4 * r));
      chk("lane write", rdat, {16'h0, MSK[r] & 16'hFF00});
    end
    bus(0, 8'h14);
    chk("unmapped resp", 32'(rsp), 32'h2);
    bus(0, 8'h09);
    chk("misaligned resp", 32'(rsp), 32'h2);
    // each source alone, at a level, then disabled
    for (int f = 0; f < 14; f++) begin
      int r;
      logic [15:0] v;
      r = (f < 4) ? 0 : (f < 8) ? 1 : 2;
      v = 16'((f % 3 + 1) << LSB[f]);
      bus(1, 8'(8 + 4 * r), {16'h0, v});
      bus(0, 8'(8 + 4 * r));
      chk("field place", rdat, {16'h0, v});
      want <= 14'(1 << f);
      repeat (2) @(posedge clock_i);
      chk("fwd", 32'(fwd), 32'(1 << f));
      chk("level", 32'(lvl), 32'(1 << (f % 3)));
      bus(1, 8'(8 + 4 * r));
      repeat (2) @(posedge clock_i);
      chk("disabled", 32'({fwd, lvl}), 32'h0);
      want <= 14'h0;
    end
    bus(1, 8'h14, 32'hFFFFFFFF);
    chk("unmapped write", 32'(rsp), 32'h2);
    bus(0, 8'h08);
    chk("after unmapped", rdat, 32'h0);
    bus(1, 8'h10, 32'h0000C010);
    want <= 14'h0900;
    repeat (2) @(posedge clock_i);
    chk("two levels", 32'(lvl), 32'h5);
    chk("two fwd", 32'(fwd), 32'h0900);
    bus(1, 8'h10, 32'h0, 4'h2);
    bus(0, 8'h10);
    chk("lane 1 write", rdat, 32'h10);
    tally_and_finish();
  end
endmodule : ipl_level_regs_tb_top
bind ipl_level_regs ipl_level_regs_asserts u_chk (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
  .avs_waitrequest_o(avs_waitrequest_o), .src_req_i(src_req_i),
  .src_fwd_o(src_fwd_o), .level_req_o(level_req_o));
